// File: rtl/tsss_defs.svh
// Constants for the timing signal source select block.
`ifndef TSSS_DEFS_SVH
`define TSSS_DEFS_SVH

// Register word offsets (byte addresses).
`define TSSS_ADDR_W 8
`define TSSS_OFS_GATE_DLY 8'h00
`define TSSS_OFS_SYNC_DLY 8'h04
`define TSSS_OFS_SRC_SEL 8'h0C
`define TSSS_OFS_SW_GATE 8'h10
`define TSSS_OFS_SW_SYNC 8'h14
`define TSSS_OFS_SW_PPS 8'h18
`define TSSS_OFS_STATUS 8'h1C
`define TSSS_OFS_IRQ_EN 8'h20
`define TSSS_OFS_IRQ_STAT 8'h24
`define TSSS_OFS_IRQ_FLAG 8'h28

// Source select field positions.
`define TSSS_SEL_MASTER_BIT 0
`define TSSS_SEL_GOUT_LSB 4
`define TSSS_SEL_GEVT_LSB 8
`define TSSS_SEL_SOUT_LSB 12
`define TSSS_SEL_SEVT_LSB 16
`define TSSS_SEL_PPS_LSB 20
`define TSSS_SEL_FLD_W 4

// Tap delay field and build-time limits.
`define TSSS_TAP_W 9
`define TSSS_TAP_MAX 511
`define TSSS_CYC_DLY_MAX 16

// Interrupt flag bits: rise/fall for gate, sync, pps.
`define TSSS_NUM_EVT 6

`endif

// File: rtl/tsss_pkg.sv
// Types for the timing signal source select block.
`default_nettype none
package tsss_pkg;
  // One timing event sample for the stream port.
  typedef struct packed {
    logic pps;
    logic sync;
    logic gate;
  } tsss_evt_type;

  // Register bus request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } tsss_bus_type;
endpackage : tsss_pkg
`default_nettype wire

// File: rtl/tsss_top.sv
// Timing signal source selection, delay, edge events and register file.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tsss_defs.svh"

// What this block does
// - Select outgoing gate from four sources
// - Select event gate, inputs true or inverted
// - Select outgoing sync, including gate edges
// - Select event sync, including gate edges
// - Select pulse-per-second from many sources
// - Outgoing lines pass only when master set
// - Events on both edges of each signal
// - LED shows selected source state
// - Programmable tap delay on incoming lines
// - Build-time whole-cycle delay on inputs
// - Registers live in sample clock domain
// - Software reaches registers as bus slave
// - Stream timing event data out
// - Master resends panel signals single-ended
// - Master bit enables external line drivers
// - Interrupt enable, status, flag registers present
// - Termination and buffer mode selectable
// - Reset gate tap delay is build value
// - Master build flag enables single-ended copies
module tsss_top #(
  parameter bit build_as_master_flag = 1'b1,
  parameter logic [8:0] initial_gate_tap_delay = 9'h000,
  parameter int cyc_dly = 2,
  parameter bit term_enable = 1'b1,
  parameter bit low_power_buf = 1'b0
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port.
  input wire tsss_pkg::tsss_bus_type bus_i,
  output logic [31:0] rdata_o,
  // Panel and user inputs.
  input wire logic lvttl_gate_i,
  input wire logic ssmc_gate_i,
  input wire logic lvds_gate_i,
  input wire logic lvttl_sync_i,
  input wire logic lvds_sync_i,
  input wire logic user_gate_i,
  input wire logic user_sync_i,
  input wire logic user_pps_i,
  // Outgoing lines and board controls.
  output logic gate_out_o,
  output logic sync_out_o,
  output logic drv_en_o,
  output logic led_o,
  output logic term_en_o,
  output logic low_power_o,
  output logic [8:0] gate_tap_o,
  output logic [8:0] sync_tap_o,
  // Single-ended copies for a second instance.
  output logic se_gate_o,
  output logic se_ssmc_o,
  output logic se_sync_o,
  // Timing event stream.
  output tsss_pkg::tsss_evt_type evt_tdata_o,
  output logic evt_tvalid_o,
  // Interrupt request level.
  output logic irq_o
);
  import tsss_pkg::*;

  // ==========================================================
  // Input synchronisers and whole-cycle delay
  // ==========================================================
  localparam int NIN = 8;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [NIN-1:0] dl_q [`TSSS_CYC_DLY_MAX];
  logic [NIN-1:0] in_d;

  assign raw_in = {user_pps_i, user_sync_i, user_gate_i, lvds_sync_i,
                   lvttl_sync_i, lvds_gate_i, ssmc_gate_i, lvttl_gate_i};

  // Two flops bring pins into the sample clock domain.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
    end
  end

  // Shift line adds the build-time cable delay to panel inputs.
  for (genvar gi = 0; gi < `TSSS_CYC_DLY_MAX; gi++) begin : g_dl
    logic [NIN-1:0] src;
    if (gi == 0) begin : g_head
      assign src = s2_q;
    end else begin : g_tail
      assign src = dl_q[gi-1];
    end
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        dl_q[gi] <= '0;
      end else begin
        dl_q[gi] <= src;
      end
    end
  end
  if (cyc_dly == 0) begin : g_nodly
    assign in_d = s2_q;
  end else begin : g_dly
    assign in_d = dl_q[cyc_dly-1];
  end

  logic i_lg, i_sg, i_dg, i_ls, i_ds, u_g, u_s, u_p;
  assign {u_p, u_s, u_g, i_ds, i_ls, i_dg, i_sg, i_lg} = in_d;

  // ==========================================================
  // Registers
  // ==========================================================
  logic [8:0] gate_tap_q, sync_tap_q;
  logic [31:0] sel_q;
  logic sw_gate_q, sw_sync_q, sw_pps_q;
  logic [`TSSS_NUM_EVT-1:0] irq_en_q, irq_flag_q, edge_ev;

  // Software writes; gate tap delay starts at build value.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gate_tap_q <= initial_gate_tap_delay;
      sync_tap_q <= '0;
      sel_q <= '0;
      sw_gate_q <= 1'b0;
      sw_sync_q <= 1'b0;
      sw_pps_q <= 1'b0;
      irq_en_q <= '0;
    end else if (bus_i.wr) begin
      if (bus_i.addr == `TSSS_OFS_GATE_DLY) begin
        gate_tap_q <= bus_i.wdata[`TSSS_TAP_W-1:0];
      end else if (bus_i.addr == `TSSS_OFS_SYNC_DLY) begin
        sync_tap_q <= bus_i.wdata[`TSSS_TAP_W-1:0];
      end else if (bus_i.addr == `TSSS_OFS_SRC_SEL) begin
        sel_q <= bus_i.wdata;
      end else if (bus_i.addr == `TSSS_OFS_SW_GATE) begin
        sw_gate_q <= bus_i.wdata[0];
      end else if (bus_i.addr == `TSSS_OFS_SW_SYNC) begin
        sw_sync_q <= bus_i.wdata[0];
      end else if (bus_i.addr == `TSSS_OFS_SW_PPS) begin
        sw_pps_q <= bus_i.wdata[0];
      end else if (bus_i.addr == `TSSS_OFS_IRQ_EN) begin
        irq_en_q <= bus_i.wdata[`TSSS_NUM_EVT-1:0];
      end
    end
  end

  // ==========================================================
  // Source selection
  // ==========================================================
  logic [3:0] f_go, f_ge, f_so, f_se, f_pp;
  logic ev_gate_q, gate_prev_q, gate_edge;
  logic gout, gevt, sout, sevt, pps;
  assign f_go = sel_q[`TSSS_SEL_GOUT_LSB +: `TSSS_SEL_FLD_W];
  assign f_ge = sel_q[`TSSS_SEL_GEVT_LSB +: `TSSS_SEL_FLD_W];
  assign f_so = sel_q[`TSSS_SEL_SOUT_LSB +: `TSSS_SEL_FLD_W];
  assign f_se = sel_q[`TSSS_SEL_SEVT_LSB +: `TSSS_SEL_FLD_W];
  assign f_pp = sel_q[`TSSS_SEL_PPS_LSB +: `TSSS_SEL_FLD_W];
  assign gate_edge = ev_gate_q ^ gate_prev_q;

  // Codes: even true, odd inverted; unlisted codes give low.
  always_comb begin
    case (f_go)
      4'h0: gout = sw_gate_q;
      4'h1: gout = ~sw_gate_q;
      4'h2: gout = i_lg;
      4'h3: gout = ~i_lg;
      4'h4: gout = i_sg;
      4'h5: gout = ~i_sg;
      4'h6: gout = u_g;
      default: gout = 1'b0;
    endcase
    case (f_ge)
      4'h0: gevt = sw_gate_q;
      4'h2: gevt = i_lg;
      4'h3: gevt = ~i_lg;
      4'h4: gevt = i_sg;
      4'h5: gevt = ~i_sg;
      4'h6: gevt = i_dg;
      4'h7: gevt = ~i_dg;
      default: gevt = 1'b0;
    endcase
    case (f_so)
      4'h0: sout = sw_sync_q;
      4'h1: sout = ~sw_sync_q;
      4'h2: sout = i_ls;
      4'h3: sout = ~i_ls;
      4'h4: sout = gate_edge;
      4'h6: sout = u_s;
      default: sout = 1'b0;
    endcase
    case (f_se)
      4'h0: sevt = sw_sync_q;
      4'h2: sevt = i_ls;
      4'h3: sevt = ~i_ls;
      4'h4: sevt = gate_edge;
      4'h6: sevt = i_ds;
      4'h7: sevt = ~i_ds;
      default: sevt = 1'b0;
    endcase
    case (f_pp)
      4'h0: pps = sw_pps_q;
      4'h2: pps = i_ls;
      4'h3: pps = ~i_ls;
      4'h4: pps = gate_edge;
      4'h6: pps = i_ds;
      4'h7: pps = ~i_ds;
      4'h8: pps = i_lg;
      4'h9: pps = ~i_lg;
      4'hA: pps = i_sg;
      4'hB: pps = ~i_sg;
      4'hC: pps = u_p;
      default: pps = 1'b0;
    endcase
  end

  // ==========================================================
  // Outputs, events and edge flags
  // ==========================================================
  logic sync_q, pps_q, sync_prev_q, pps_prev_q, master_q;
  assign master_q = sel_q[`TSSS_SEL_MASTER_BIT];

  // Registered selections and their previous samples.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ev_gate_q <= 1'b0;
      sync_q <= 1'b0;
      pps_q <= 1'b0;
      gate_prev_q <= 1'b0;
      sync_prev_q <= 1'b0;
      pps_prev_q <= 1'b0;
      gate_out_o <= 1'b0;
      sync_out_o <= 1'b0;
      evt_tdata_o <= '0;
      evt_tvalid_o <= 1'b0;
      led_o <= 1'b0;
    end else begin
      ev_gate_q <= gevt;
      sync_q <= sevt;
      pps_q <= pps;
      gate_prev_q <= ev_gate_q;
      sync_prev_q <= sync_q;
      pps_prev_q <= pps_q;
      gate_out_o <= gout & master_q;
      sync_out_o <= sout & master_q;
      evt_tdata_o <= '{pps: pps_q, sync: sync_q, gate: ev_gate_q};
      evt_tvalid_o <= 1'b1;
      led_o <= ev_gate_q;
    end
  end

  assign edge_ev = {pps_q & ~pps_prev_q, ~pps_q & pps_prev_q,
                    sync_q & ~sync_prev_q, ~sync_q & sync_prev_q,
                    ev_gate_q & ~gate_prev_q, ~ev_gate_q & gate_prev_q};

  // Sticky flags; a set in the clearing cycle wins.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_flag_q <= '0;
    end else if (bus_i.wr && bus_i.addr == `TSSS_OFS_IRQ_FLAG) begin
      irq_flag_q <= (irq_flag_q & ~bus_i.wdata[`TSSS_NUM_EVT-1:0]) | edge_ev;
    end else begin
      irq_flag_q <= irq_flag_q | edge_ev;
    end
  end
  assign irq_o = |(irq_flag_q & irq_en_q);

  assign drv_en_o = master_q;
  assign gate_tap_o = gate_tap_q;
  assign sync_tap_o = sync_tap_q;
  assign term_en_o = term_enable;
  assign low_power_o = low_power_buf;
  assign se_gate_o = build_as_master_flag & s2_q[0];
  assign se_ssmc_o = build_as_master_flag & s2_q[1];
  assign se_sync_o = build_as_master_flag & s2_q[3];

  // Read data one cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (bus_i.rd) begin
      if (bus_i.addr == `TSSS_OFS_GATE_DLY) rdata_o <= {23'h0, gate_tap_q};
      else if (bus_i.addr == `TSSS_OFS_SYNC_DLY) rdata_o <= {23'h0, sync_tap_q};
      else if (bus_i.addr == `TSSS_OFS_SRC_SEL) rdata_o <= sel_q;
      else if (bus_i.addr == `TSSS_OFS_SW_GATE) rdata_o <= {31'h0, sw_gate_q};
      else if (bus_i.addr == `TSSS_OFS_SW_SYNC) rdata_o <= {31'h0, sw_sync_q};
      else if (bus_i.addr == `TSSS_OFS_SW_PPS) rdata_o <= {31'h0, sw_pps_q};
      else if (bus_i.addr == `TSSS_OFS_STATUS) rdata_o <= {29'h0, pps_q, sync_q, ev_gate_q};
      else if (bus_i.addr == `TSSS_OFS_IRQ_EN) rdata_o <= {26'h0, irq_en_q};
      else if (bus_i.addr == `TSSS_OFS_IRQ_STAT) rdata_o <= {26'h0, irq_flag_q & irq_en_q};
      else if (bus_i.addr == `TSSS_OFS_IRQ_FLAG) rdata_o <= {26'h0, irq_flag_q};
      else rdata_o <= '0;
    end else begin
      rdata_o <= '0;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  gate_gated_a: assert property (!master_q |=> !gate_out_o)
    else $error("gate out while master off");
  sync_gated_a: assert property (!master_q |=> !sync_out_o)
    else $error("sync out while master off");
  drv_enable_a: assert property (bus_i.wr && bus_i.addr == `TSSS_OFS_SRC_SEL |=>
    drv_en_o == $past(bus_i.wdata[`TSSS_SEL_MASTER_BIT])) else $error("driver enable mismatch");
  gate_rise_a: assert property ($rose(ev_gate_q) |=> irq_flag_q[1])
    else $error("gate rise not flagged");
  gate_fall_a: assert property ($fell(ev_gate_q) |=> irq_flag_q[0])
    else $error("gate fall not flagged");
  pps_edge_a: assert property ($changed(pps_q) |=> |irq_flag_q[5:4])
    else $error("pps edge not flagged");
  irq_mask_a: assert property (irq_en_q == '0 |-> !irq_o)
    else $error("irq with no enable");
  flag_sticky_a: assert property (irq_flag_q[2] && !bus_i.wr |=> irq_flag_q[2])
    else $error("flag lost");
  read_zero_a: assert property (!bus_i.rd |=> rdata_o == '0)
    else $error("read data without strobe");
  led_follow_a: assert property (1'b1 |=> led_o == $past(ev_gate_q))
    else $error("led not tracking gate");

  master_on_c: cover property ($rose(master_q));
  irq_fire_c: cover property ($rose(irq_o));
  sync_edge_c: cover property ($rose(sync_q) ##[1:20] $fell(sync_q));
endmodule : tsss_top
`default_nettype wire

// File: bench/tsss_panel_model.sv
// Front-panel bus model that drives the incoming lines and shows the released bus.
`timescale 1ns/1ps
`default_nettype none

module tsss_panel_model (
  // Clock.
  input wire logic clock_i,
  // Levels wanted on the panel: {lvds_sync, lvttl_sync, lvds_gate, ssmc_gate, lvttl_gate}.
  input wire logic [4:0] set_i,
  // Outgoing lines of the block and their driver enable.
  input wire logic gate_out_i,
  input wire logic sync_out_i,
  input wire logic drv_en_i,
  // Incoming lines towards the block.
  output logic [4:0] line_o,
  // What other boards see on the bus.
  output logic bus_gate_o,
  output logic bus_sync_o
);
  // ==========================================================
  // Panel lines
  // Lines move just after a clock edge, as a real source would.
  always_ff @(posedge clock_i) begin
    line_o <= set_i;
  end

  // The terminated bus is pulled low when the external drivers are off.
  assign bus_gate_o = drv_en_i ? gate_out_i : 1'b0;
  assign bus_sync_o = drv_en_i ? sync_out_i : 1'b0;
endmodule : tsss_panel_model

`default_nettype wire

// File: bench/tsss_top_tb.sv
// Self-checking testbench for the timing signal source select block.
`timescale 1ns/1ps
`default_nettype none
`include "tsss_defs.svh"

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end

module tsss_top_tb;
  import tsss_pkg::*;
  localparam int CYC = 2;
  localparam int LAT = 2 + CYC + 3;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  tsss_bus_type bus_q = '0;
  logic [4:0] set_q = 5'h00;
  logic [2:0] user_q = 3'h0;
  logic [4:0] line;
  logic [31:0] rdata_o;
  logic gate_out_o, sync_out_o, drv_en_o, led_o, term_en_o, low_power_o, irq_o;
  logic se_gate_o, se_ssmc_o, se_sync_o, evt_tvalid_o, bus_gate, bus_sync;
  logic [8:0] gate_tap_o, sync_tap_o;
  tsss_evt_type evt_tdata_o;
  int errors = 0;
  int tests_run = 0;
  logic [31:0] rd_v;
  logic [6:0] gout_exp = 7'b1100110;
  logic [7:0] gevt_exp = 8'hA4;
  logic [7:0] sevt_exp = 8'h84;
  logic [12:0] pps_exp = 13'h1984;

  // ==========================================================
  // Design and panel model
  tsss_top #(.initial_gate_tap_delay(9'h155), .cyc_dly(CYC)) u_tsss_top (
    .clock_i(clock_i), .rst_i(rst_i), .bus_i(bus_q), .rdata_o(rdata_o),
    .lvttl_gate_i(line[0]), .ssmc_gate_i(line[1]), .lvds_gate_i(line[2]),
    .lvttl_sync_i(line[3]), .lvds_sync_i(line[4]), .user_gate_i(user_q[0]),
    .user_sync_i(user_q[1]), .user_pps_i(user_q[2]), .gate_out_o(gate_out_o),
    .sync_out_o(sync_out_o), .drv_en_o(drv_en_o), .led_o(led_o), .term_en_o(term_en_o),
    .low_power_o(low_power_o), .gate_tap_o(gate_tap_o), .sync_tap_o(sync_tap_o),
    .se_gate_o(se_gate_o), .se_ssmc_o(se_ssmc_o), .se_sync_o(se_sync_o),
    .evt_tdata_o(evt_tdata_o), .evt_tvalid_o(evt_tvalid_o), .irq_o(irq_o));

  tsss_panel_model u_tsss_panel_model (
    .clock_i(clock_i), .set_i(set_q), .gate_out_i(gate_out_o), .sync_out_i(sync_out_o),
    .drv_en_i(drv_en_o), .line_o(line), .bus_gate_o(bus_gate), .bus_sync_o(bus_sync));

  // Clock of 5 ns period.
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  // ==========================================================
  // Bus tasks
  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    bus_q <= '0;
  endtask : wr

  // One-cycle read strobe; data is taken in the following cycle.
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    bus_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock_i);
    bus_q <= '0;
    #1 rd_v = rdata_o;
  endtask : rd

  // Lets a level change run through the input pipeline.
  task automatic settle();
    repeat (LAT) @(posedge clock_i);
    #1;
  endtask : settle

  // ==========================================================
  // Scenarios
  // Reset values and build-time outputs.
  task automatic t_reset();
    rd(`TSSS_OFS_SRC_SEL);
    `CHK("src_sel", 32'h0, rd_v)
    `CHK("drv_en", 1'b0, drv_en_o)
    `CHK("gate_tap", 9'h155, gate_tap_o)
    `CHK("term_en", 1'b1, term_en_o)
    `CHK("low_power", 1'b0, low_power_o)
    `CHK("tvalid", 1'b1, evt_tvalid_o)
    rd(8'h3C);
    `CHK("unmapped", 32'h0, rd_v)
    rd(`TSSS_OFS_GATE_DLY);
    `CHK("gate_dly_rd", 32'h155, rd_v)
    @(posedge clock_i);
    #1;
    `CHK("rdata_gone", 32'h0, rdata_o)
  endtask : t_reset

  // Outgoing gate is held off the bus until the master bit is set.
  task automatic t_master();
    wr(`TSSS_OFS_SRC_SEL, 32'h0000_0010);
    settle();
    `CHK("gate_off", 1'b0, bus_gate)
    `CHK("gate_out_off", 1'b0, gate_out_o)
    wr(`TSSS_OFS_SRC_SEL, 32'h0000_0011);
    #1;
    `CHK("drv_en_now", 1'b1, drv_en_o)
    settle();
    `CHK("drv_en_on", 1'b1, drv_en_o)
    `CHK("gate_on", 1'b1, bus_gate)
  endtask : t_master

  // Every outgoing gate source code with sw 0, lvttl 1, ssmc 0, user 1.
  task automatic t_gate_codes();
    @(posedge clock_i);
    set_q <= 5'h01;
    user_q <= 3'h1;
    for (int c = 0; c < 7; c++) begin
      wr(`TSSS_OFS_SRC_SEL, 32'h1 | (c << `TSSS_SEL_GOUT_LSB));
      settle();
      `CHK("gate_out", gout_exp[c], gate_out_o)
    end
    `CHK("se_gate", 1'b1, se_gate_o)
  endtask : t_gate_codes

  // Inverted lvds gate and sync for events, inverted lvttl sync out, user pps, taps.
  task automatic t_event_sel();
    @(posedge clock_i);
    set_q <= 5'h03;
    user_q <= 3'h5;
    wr(`TSSS_OFS_SRC_SEL, 32'h00C7_3701);
    wr(`TSSS_OFS_GATE_DLY, 32'h1FF);
    wr(`TSSS_OFS_SYNC_DLY, 32'h0AA);
    settle();
    `CHK("evt_gate", 1'b1, evt_tdata_o.gate)
    `CHK("led", 1'b1, led_o)
    `CHK("sync_out", 1'b1, sync_out_o)
    `CHK("evt_sync", 1'b1, evt_tdata_o.sync)
    `CHK("pps_user", 1'b1, evt_tdata_o.pps)
    `CHK("tap", 9'h1FF, gate_tap_o)
    `CHK("sync_tap", 9'h0AA, sync_tap_o)
    `CHK("se_ssmc", 1'b1, se_ssmc_o)
    rd(`TSSS_OFS_STATUS);
    `CHK("status", 32'h7, rd_v)
    @(posedge clock_i);
    set_q <= 5'h0B;
    settle();
    `CHK("sync_out_inv", 1'b0, sync_out_o)
    `CHK("se_sync", 1'b1, se_sync_o)
  endtask : t_event_sel

  // Enabled and masked edges of the software gate.
  task automatic t_irq();
    wr(`TSSS_OFS_SRC_SEL, 32'h0000_0001);
    wr(`TSSS_OFS_SW_GATE, 32'h0);
    settle();
    wr(`TSSS_OFS_IRQ_FLAG, 32'h3F);
    wr(`TSSS_OFS_IRQ_EN, 32'h2);
    wr(`TSSS_OFS_SW_GATE, 32'h1);
    settle();
    `CHK("irq_rise", 1'b1, irq_o)
    rd(`TSSS_OFS_IRQ_FLAG);
    `CHK("flag_rise", 32'h2, rd_v)
    wr(`TSSS_OFS_IRQ_FLAG, 32'h2);
    wr(`TSSS_OFS_SW_GATE, 32'h0);
    settle();
    `CHK("irq_masked", 1'b0, irq_o)
    rd(`TSSS_OFS_IRQ_FLAG);
    `CHK("flag_fall", 32'h1, rd_v)
    rd(`TSSS_OFS_IRQ_STAT);
    `CHK("irq_stat", 32'h0, rd_v)
  endtask : t_irq

  // Every event gate, event sync and pulse-per-second code against fixed pin levels.
  task automatic t_evt_codes();
    @(posedge clock_i);
    set_q <= 5'h09;
    user_q <= 3'h4;
    for (int c = 0; c < 8; c++) begin
      wr(`TSSS_OFS_SRC_SEL, 32'h1 | (c << `TSSS_SEL_GEVT_LSB) | (c << `TSSS_SEL_SEVT_LSB));
      settle();
      `CHK("evt_gate_code", gevt_exp[c], evt_tdata_o.gate)
      `CHK("evt_sync_code", sevt_exp[c], evt_tdata_o.sync)
    end
    for (int c = 0; c < 13; c++) begin
      wr(`TSSS_OFS_SRC_SEL, 32'h1 | (c << `TSSS_SEL_PPS_LSB));
      settle();
      `CHK("pps_code", pps_exp[c], evt_tdata_o.pps)
    end
  endtask : t_evt_codes

  // A panel change reaches the outgoing gate only after the build-time cycle delay.
  task automatic t_cable_delay();
    wr(`TSSS_OFS_SRC_SEL, 32'h0000_0021);
    settle();
    `CHK("gate_lvttl", 1'b1, gate_out_o)
    @(posedge clock_i);
    set_q <= 5'h08;
    repeat (3 + CYC) @(posedge clock_i);
    #1;
    `CHK("gate_held", 1'b1, gate_out_o)
    @(posedge clock_i);
    #1;
    `CHK("gate_late", 1'b0, gate_out_o)
  endtask : t_cable_delay

  // A rise of the event gate becomes a one-cycle sync pulse and sets its flags.
  task automatic t_gate_edge();
    int n;
    n = 0;
    wr(`TSSS_OFS_SRC_SEL, 32'h0004_4001);
    settle();
    wr(`TSSS_OFS_IRQ_FLAG, 32'h3F);
    wr(`TSSS_OFS_SW_GATE, 32'h1);
    repeat (LAT) begin
      @(posedge clock_i);
      #1;
      if (sync_out_o === 1'b1) n++;
    end
    `CHK("sync_pulse", 32'h1, n)
    `CHK("irq_edge", 1'b1, irq_o)
    rd(`TSSS_OFS_IRQ_FLAG);
    `CHK("flag_edges", 32'hE, rd_v)
  endtask : t_gate_edge

  // ==========================================================
  // Verdict
  task automatic report_and_stop();
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence after a six-cycle reset.
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    t_reset();
    t_master();
    t_gate_codes();
    t_event_sel();
    t_irq();
    t_evt_codes();
    t_cable_delay();
    t_gate_edge();
    report_and_stop();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial begin
    #50000;
    errors++;
    report_and_stop();
  end
endmodule : tsss_top_tb

`default_nettype wire
